// file: logic/piezo_drive_register_control.sv
/*
 * Register set, drive period generator, pulse counter and bridge blend of the piezo driver.
 * Assumes a serial slave on clk_sys presents decoded byte accesses; power-down and supply
 * comparator arrive asynchronously from pins and analogue and are synchronised here.
 */
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////////////////////////
module piezo_drive_register_control #(
	parameter int PERIOD_WIDTH = 9,
	parameter int PULSE_WIDTH = 11
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire piezo_drive_pkg::host_access_s host_access,
	input wire logic power_down_pin_n,
	input wire logic supply_above_threshold,
	output logic [7:0] rd_data,
	output piezo_drive_pkg::bridge_drive_s bridge_drive,
	output logic period_tick,
	output logic motor_running,
	output logic direction,
	output logic full_bridge,
	output logic calibration_run,
	output logic [1:0] calibration_mode,
	output logic [1:0] sense_phase_select,
	output logic [PULSE_WIDTH-1:0] pulses_remaining
);

	localparam int CNT_WIDTH = PERIOD_WIDTH + 1;

	typedef struct packed {
		logic [7:0] drive_control;
		logic [7:0] period_count_low;
		logic [7:0] pulse_count_high;
		logic [7:0] pulse_count_low;
		logic [7:0] duty_cycle;
		logic [7:0] phase_offset;
		logic [7:0] frequency_offset_modes;
		logic [7:0] bridge_blend_speed;
		logic pd_meta;
		logic pd_sync;
		logic sup_meta;
		logic sup_sync;
		piezo_drive_pkg::drive_state_e state;
		logic [CNT_WIDTH-1:0] period_cnt;
		logic [PULSE_WIDTH-1:0] pulses_left;
		logic high_loaded;
		logic low_loaded;
		logic [7:0] blend_acc;
		logic full_bridge;
		logic cal_run;
		logic tick;
		piezo_drive_pkg::bridge_drive_s drive;
		logic [7:0] rd_data;
	} ctl_state_s;

	ctl_state_s state_q;
	ctl_state_s state_d;

	////////////////////////////////////////////////////////////////////////////////////////////////
	// field views of the registers

	logic [1:0] cal_req;
	logic [PERIOD_WIDTH-1:0] period_base;
	logic [CNT_WIDTH-1:0] period_len;
	logic [CNT_WIDTH-1:0] half_len;
	logic [CNT_WIDTH-1:0] quarter_len;
	logic [CNT_WIDTH-1:0] dead_len;
	logic [CNT_WIDTH-1:0] cnt_b;
	logic [CNT_WIDTH:0] cnt_b_wide;
	logic [PULSE_WIDTH-1:0] pulse_load;
	logic [1:0] dead_sel;
	logic [8:0] blend_sum;
	logic period_end;
	logic wr_hit;

	// the serial slave never sees address 10h; such accesses fall into the default arm
	assign wr_hit = state_q.pd_sync && host_access.wr_en;
	assign cal_req = state_q.drive_control[piezo_drive_pkg::CAL_REQ_LSB +: 2];
	assign period_base = {state_q.pulse_count_high[piezo_drive_pkg::PERIOD_MSB_BIT],
		state_q.period_count_low};
	assign dead_sel = state_q.pulse_count_high[piezo_drive_pkg::DEAD_SEL_LSB +: 2];
	assign pulse_load = {state_q.pulse_count_high[piezo_drive_pkg::PULSE_HIGH_WIDTH-1:0],
		state_q.pulse_count_low};

	// offset only lengthens the period, and only while tracking is idle
	always_comb begin
		period_len = {1'b0, period_base};
		if (cal_req == piezo_drive_pkg::CAL_NONE) begin
			period_len = period_len + CNT_WIDTH'(state_q.frequency_offset_modes[piezo_drive_pkg::OFFSET_WIDTH-1:0]);
		end
	end

	assign half_len = period_len >> 1;
	assign quarter_len = period_len >> 2;

	// dead time: fixed two cycles unless the long dead time mode unlocks the selection
	always_comb begin
		dead_len = CNT_WIDTH'(piezo_drive_pkg::DEAD_STEP_CYCLES);
		if (state_q.frequency_offset_modes[piezo_drive_pkg::LONG_DEAD_EN_BIT]) begin
			dead_len = CNT_WIDTH'(piezo_drive_pkg::DEAD_STEP_CYCLES) * CNT_WIDTH'({2'b00, dead_sel} + 4'h1);
		end
	end

	// phase b runs a quarter period ahead of phase a
	assign cnt_b_wide = {1'b0, state_q.period_cnt} + {1'b0, quarter_len};
	assign cnt_b = (cnt_b_wide >= {1'b0, period_len}) ? CNT_WIDTH'(cnt_b_wide - {1'b0, period_len})
		: cnt_b_wide[CNT_WIDTH-1:0];

	// one period every N clocks; N of one ticks every clock
	assign period_end = (state_q.period_cnt >= period_len - CNT_WIDTH'(1));
	assign blend_sum = {1'b0, state_q.blend_acc} + {1'b0, state_q.bridge_blend_speed};

	////////////////////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		state_d = state_q;
		state_d.tick = 1'b0;

		// two-stage synchronisers for the pin and the supply comparator
		state_d.pd_meta = power_down_pin_n;
		state_d.pd_sync = state_q.pd_meta;
		state_d.sup_meta = supply_above_threshold;
		state_d.sup_sync = state_q.sup_meta;

		// host writes; registers otherwise hold their values
		if (wr_hit) begin
			case (host_access.addr)
				piezo_drive_pkg::ADDR_DRIVE_CONTROL: begin
					state_d.drive_control = host_access.wr_data & piezo_drive_pkg::DRIVE_CONTROL_WRITABLE;
				end
				piezo_drive_pkg::ADDR_PERIOD_COUNT_LOW: begin
					state_d.period_count_low = host_access.wr_data;
				end
				piezo_drive_pkg::ADDR_PULSE_COUNT_HIGH: begin
					state_d.pulse_count_high = host_access.wr_data;
					state_d.high_loaded = 1'b1;
				end
				piezo_drive_pkg::ADDR_PULSE_COUNT_LOW: begin
					state_d.pulse_count_low = host_access.wr_data;
					state_d.low_loaded = 1'b1;
				end
				piezo_drive_pkg::ADDR_DUTY_CYCLE: begin
					state_d.duty_cycle = host_access.wr_data;
				end
				piezo_drive_pkg::ADDR_PHASE_OFFSET: begin
					state_d.phase_offset = host_access.wr_data;
				end
				piezo_drive_pkg::ADDR_FREQUENCY_OFFSET_MODES: begin
					state_d.frequency_offset_modes = host_access.wr_data;
				end
				piezo_drive_pkg::ADDR_BRIDGE_BLEND_SPEED: begin
					state_d.bridge_blend_speed = host_access.wr_data;
				end
				default: begin
				end
			endcase
		end

		// read data is captured one clock after the strobe; unmapped and test space read zero
		if (host_access.rd_en) begin
			case (host_access.addr)
				piezo_drive_pkg::ADDR_DRIVE_CONTROL: state_d.rd_data = state_q.drive_control;
				piezo_drive_pkg::ADDR_PERIOD_COUNT_LOW: state_d.rd_data = state_q.period_count_low;
				piezo_drive_pkg::ADDR_PULSE_COUNT_HIGH: state_d.rd_data = state_q.pulse_count_high;
				piezo_drive_pkg::ADDR_PULSE_COUNT_LOW: state_d.rd_data = state_q.pulse_count_low;
				piezo_drive_pkg::ADDR_DUTY_CYCLE: state_d.rd_data = state_q.duty_cycle;
				piezo_drive_pkg::ADDR_PHASE_OFFSET: state_d.rd_data = state_q.phase_offset;
				piezo_drive_pkg::ADDR_FREQUENCY_OFFSET_MODES: state_d.rd_data = state_q.frequency_offset_modes;
				piezo_drive_pkg::ADDR_BRIDGE_BLEND_SPEED: state_d.rd_data = state_q.bridge_blend_speed;
				default: state_d.rd_data = piezo_drive_pkg::RST_ZERO;
			endcase
		end

		// drive sequencer
		case (state_q.state)
			piezo_drive_pkg::ST_STOP: begin
				state_d.period_cnt = '0;
			end
			piezo_drive_pkg::ST_RUN: begin
				if (state_q.frequency_offset_modes[piezo_drive_pkg::LOW_POWER_HOLD_BIT]) begin
					state_d.state = piezo_drive_pkg::ST_HOLD;
				end else if (period_len == '0) begin
					state_d.state = piezo_drive_pkg::ST_STOP;
				end else if (period_end) begin
					state_d.period_cnt = '0;
					state_d.tick = 1'b1;
					state_d.pulses_left = state_q.pulses_left - PULSE_WIDTH'(1);
					// blend: accumulate speed, each carry of 128 earns one full bridge period
					if (!state_q.frequency_offset_modes[piezo_drive_pkg::BLEND_EN_BIT]) begin
						state_d.full_bridge = !(state_q.frequency_offset_modes[piezo_drive_pkg::HALF_BRIDGE_EN_BIT]
							&& state_q.sup_sync);
					end else if (blend_sum >= piezo_drive_pkg::BLEND_FULL_SCALE) begin
						state_d.full_bridge = 1'b1;
						state_d.blend_acc = 8'(blend_sum - piezo_drive_pkg::BLEND_FULL_SCALE);
					end else begin
						state_d.full_bridge = 1'b0;
						state_d.blend_acc = blend_sum[7:0];
					end
					if (state_q.pulses_left == PULSE_WIDTH'(1)) begin
						state_d.state = piezo_drive_pkg::ST_STOP;
					end
				end else begin
					state_d.period_cnt = state_q.period_cnt + CNT_WIDTH'(1);
				end
			end
			piezo_drive_pkg::ST_HOLD: begin
				// hold keeps the counters so that drive resumes where it paused
				if (!state_q.frequency_offset_modes[piezo_drive_pkg::LOW_POWER_HOLD_BIT]) begin
					state_d.state = piezo_drive_pkg::ST_RUN;
				end
			end
			default: begin
				state_d.state = piezo_drive_pkg::ST_STOP;
			end
		endcase

		// a new pulse count restarts the run; zero stops at once, even mid count
		if (wr_hit && (host_access.addr == piezo_drive_pkg::ADDR_PULSE_COUNT_HIGH
			|| host_access.addr == piezo_drive_pkg::ADDR_PULSE_COUNT_LOW)) begin
			state_d.pulses_left = (host_access.addr == piezo_drive_pkg::ADDR_PULSE_COUNT_LOW)
				? {pulse_load[PULSE_WIDTH-1:8], host_access.wr_data}
				: {host_access.wr_data[piezo_drive_pkg::PULSE_HIGH_WIDTH-1:0], pulse_load[7:0]};
			state_d.period_cnt = '0;
			// a restart during idle mode stays parked so the legs never flick on for a cycle
			if (state_d.pulses_left == '0) begin
				state_d.state = piezo_drive_pkg::ST_STOP;
			end else if (state_q.frequency_offset_modes[piezo_drive_pkg::LOW_POWER_HOLD_BIT]) begin
				state_d.state = piezo_drive_pkg::ST_HOLD;
			end else begin
				state_d.state = piezo_drive_pkg::ST_RUN;
			end
		end

		// calibration request only runs after both pulse count bytes were loaded
		state_d.cal_run = state_q.high_loaded && state_q.low_loaded
			&& (cal_req == piezo_drive_pkg::CAL_INCREMENTAL || cal_req == piezo_drive_pkg::CAL_SWEEP);

		// bridge legs with dead time before each leg turns on; low in stop and hold
		state_d.drive = '0;
		if (state_q.state == piezo_drive_pkg::ST_RUN) begin
			if (state_q.drive_control[piezo_drive_pkg::PHASE_A_EN_BIT]) begin
				state_d.drive.a_high = (state_q.period_cnt >= dead_len) && (state_q.period_cnt < half_len);
				state_d.drive.a_low = (state_q.period_cnt >= half_len + dead_len);
			end
			if (state_q.drive_control[piezo_drive_pkg::PHASE_B_EN_BIT]) begin
				state_d.drive.b_high = (cnt_b >= dead_len) && (cnt_b < half_len);
				state_d.drive.b_low = (cnt_b >= half_len + dead_len);
			end
		end

		// power-down returns every register and the sequencer to defaults
		if (!state_q.pd_sync) begin
			state_d.drive_control = piezo_drive_pkg::RST_DRIVE_CONTROL;
			state_d.period_count_low = piezo_drive_pkg::RST_ZERO;
			state_d.pulse_count_high = piezo_drive_pkg::RST_ZERO;
			state_d.pulse_count_low = piezo_drive_pkg::RST_ZERO;
			state_d.duty_cycle = piezo_drive_pkg::RST_ZERO;
			state_d.phase_offset = piezo_drive_pkg::RST_ZERO;
			state_d.frequency_offset_modes = piezo_drive_pkg::RST_ZERO;
			state_d.bridge_blend_speed = piezo_drive_pkg::RST_BRIDGE_BLEND_SPEED;
			state_d.state = piezo_drive_pkg::ST_STOP;
			state_d.period_cnt = '0;
			state_d.pulses_left = '0;
			state_d.high_loaded = 1'b0;
			state_d.low_loaded = 1'b0;
			state_d.blend_acc = '0;
			state_d.cal_run = 1'b0;
			// full bridge is the reset view of the blend state
			state_d.full_bridge = 1'b1;
			state_d.tick = 1'b0;
			state_d.drive = '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////
	// state register

	// synchronous reset; pin synchronisers start as if power-down were released
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			state_q.drive_control <= piezo_drive_pkg::RST_DRIVE_CONTROL;
			state_q.period_count_low <= piezo_drive_pkg::RST_ZERO;
			state_q.pulse_count_high <= piezo_drive_pkg::RST_ZERO;
			state_q.pulse_count_low <= piezo_drive_pkg::RST_ZERO;
			state_q.duty_cycle <= piezo_drive_pkg::RST_ZERO;
			state_q.phase_offset <= piezo_drive_pkg::RST_ZERO;
			state_q.frequency_offset_modes <= piezo_drive_pkg::RST_ZERO;
			state_q.bridge_blend_speed <= piezo_drive_pkg::RST_BRIDGE_BLEND_SPEED;
			state_q.pd_meta <= 1'b1;
			state_q.pd_sync <= 1'b1;
			state_q.sup_meta <= 1'b0;
			state_q.sup_sync <= 1'b0;
			state_q.state <= piezo_drive_pkg::ST_STOP;
			state_q.period_cnt <= '0;
			state_q.pulses_left <= '0;
			state_q.high_loaded <= 1'b0;
			state_q.low_loaded <= 1'b0;
			state_q.blend_acc <= '0;
			state_q.full_bridge <= 1'b1;
			state_q.cal_run <= 1'b0;
			state_q.tick <= 1'b0;
			state_q.drive <= '0;
			state_q.rd_data <= piezo_drive_pkg::RST_ZERO;
		end else begin
			state_q <= state_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////
	// outputs, each a field of the state register

	assign rd_data = state_q.rd_data;
	assign bridge_drive = state_q.drive;
	assign period_tick = state_q.tick;
	assign motor_running = state_q.state[1];
	assign direction = state_q.pulse_count_high[piezo_drive_pkg::DIRECTION_BIT];
	assign full_bridge = state_q.full_bridge;
	assign calibration_run = state_q.cal_run;
	assign calibration_mode = state_q.drive_control[piezo_drive_pkg::CAL_REQ_LSB +: 2];
	assign sense_phase_select = state_q.drive_control[piezo_drive_pkg::SENSE_SEL_LSB +: 2];
	assign pulses_remaining = state_q.pulses_left;

endmodule : piezo_drive_register_control

// file: logic/piezo_drive_pkg.sv
/*
 * Shared constants and carrier types of the piezo drive register and period logic.
 * Assumes a byte-wide register port fed by a two-wire serial slave on the same clock.
 */
package piezo_drive_pkg;

	// register byte addresses
	localparam logic [7:0] ADDR_DRIVE_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_PERIOD_COUNT_LOW = 8'h01;
	localparam logic [7:0] ADDR_PULSE_COUNT_HIGH = 8'h02;
	localparam logic [7:0] ADDR_PULSE_COUNT_LOW = 8'h03;
	localparam logic [7:0] ADDR_DUTY_CYCLE = 8'h04;
	localparam logic [7:0] ADDR_PHASE_OFFSET = 8'h05;
	localparam logic [7:0] ADDR_FREQUENCY_OFFSET_MODES = 8'h06;
	localparam logic [7:0] ADDR_BRIDGE_BLEND_SPEED = 8'h07;
	localparam logic [7:0] ADDR_TEST_ONLY = 8'h10;

	// reset values and the drive_control write mask
	localparam logic [7:0] RST_DRIVE_CONTROL = 8'h63;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_BRIDGE_BLEND_SPEED = 8'h80;
	localparam logic [7:0] DRIVE_CONTROL_WRITABLE = 8'h6F;

	// drive_control fields
	localparam int SENSE_SEL_LSB = 5;
	localparam int CAL_REQ_LSB = 2;
	localparam int PHASE_A_EN_BIT = 1;
	localparam int PHASE_B_EN_BIT = 0;
	localparam logic [1:0] CAL_NONE = 2'h0;
	localparam logic [1:0] CAL_INCREMENTAL = 2'h1;
	localparam logic [1:0] CAL_SWEEP = 2'h2;

	// pulse_count_high fields
	localparam int PERIOD_MSB_BIT = 7;
	localparam int DIRECTION_BIT = 6;
	localparam int DEAD_SEL_LSB = 4;
	localparam int PULSE_HIGH_WIDTH = 3;

	// frequency_offset_modes fields
	localparam int LOW_POWER_HOLD_BIT = 7;
	localparam int HALF_BRIDGE_EN_BIT = 6;
	localparam int BLEND_EN_BIT = 5;
	localparam int LONG_DEAD_EN_BIT = 4;
	localparam int OFFSET_WIDTH = 3;

	// timing: drive clock 25 MHz, dead time in steps of two clocks
	localparam int VCO_FREQ_HZ = 25000000;
	localparam logic [3:0] DEAD_STEP_CYCLES = 4'h2;
	localparam logic [8:0] BLEND_FULL_SCALE = 9'h080;

	typedef enum logic [2:0] {
		ST_STOP = 3'b001,
		ST_RUN = 3'b010,
		ST_HOLD = 3'b100
	} drive_state_e;

	// one host register access, already decoded by the serial slave
	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [7:0] addr;
		logic [7:0] wr_data;
	} host_access_s;

	// bridge leg enables of both phases
	typedef struct packed {
		logic a_high;
		logic a_low;
		logic b_high;
		logic b_low;
	} bridge_drive_s;

endpackage : piezo_drive_pkg

// file: tb/piezo_drive_monitor.sv
/*
 * Port checker of the piezo drive register block.
 * Assumes one clock, synchronous active-low reset, bound onto the block below.
 */
`timescale 1ns/1ns
module piezo_drive_monitor #(
	parameter int PERIOD_WIDTH = 9,
	parameter int PULSE_WIDTH = 11
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire piezo_drive_pkg::host_access_s host_access,
	input wire logic power_down_pin_n,
	input wire logic [7:0] rd_data,
	input wire piezo_drive_pkg::bridge_drive_s bridge_drive,
	input wire logic period_tick,
	input wire logic motor_running,
	input wire logic direction,
	input wire logic calibration_run,
	input wire logic [1:0] calibration_mode,
	input wire logic [1:0] sense_phase_select
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	////////////////////////////////////////////////////////////////////////
	// writes only count when the pin was high long enough to clear the synchroniser
	rd_unmapped_a: assert property (host_access.rd_en && host_access.addr > 8'h07 |=> rd_data == 8'h00)
		else $error("unmapped read gave nonzero data");
	legs_idle_a: assert property (!motor_running [*3] |-> bridge_drive == '0)
		else $error("bridge legs driven while stopped");
	tick_pulse_a: assert property (period_tick |=> !period_tick)
		else $error("period tick longer than one cycle");
	tick_in_run_a: assert property (period_tick |-> $past(motor_running))
		else $error("period tick outside run state");
	sense_follow_a: assert property (host_access.wr_en && host_access.addr == 8'h00 && power_down_pin_n
		&& $past(power_down_pin_n) && $past(power_down_pin_n, 2)
		|=> sense_phase_select == $past(host_access.wr_data[6:5]))
		else $error("sense phase select not updated");
	cal_follow_a: assert property (host_access.wr_en && host_access.addr == 8'h00 && power_down_pin_n
		&& $past(power_down_pin_n) && $past(power_down_pin_n, 2)
		|=> calibration_mode == $past(host_access.wr_data[3:2]))
		else $error("calibration mode not updated");
	dir_follow_a: assert property (host_access.wr_en && host_access.addr == 8'h02 && power_down_pin_n
		&& $past(power_down_pin_n) && $past(power_down_pin_n, 2)
		|=> direction == $past(host_access.wr_data[6]))
		else $error("direction not updated");
	cal_start_a: assert property ($rose(calibration_run)
		|-> $past(host_access.wr_en) || $past(host_access.wr_en, 2))
		else $error("calibration started without a host write");
endmodule : piezo_drive_monitor

bind piezo_drive_register_control piezo_drive_monitor #(.PERIOD_WIDTH(PERIOD_WIDTH), .PULSE_WIDTH(PULSE_WIDTH)) mon (
	.clk_sys(clk_sys), .reset_n(reset_n), .host_access(host_access), .power_down_pin_n(power_down_pin_n),
	.rd_data(rd_data), .bridge_drive(bridge_drive), .period_tick(period_tick), .motor_running(motor_running),
	.direction(direction), .calibration_run(calibration_run), .calibration_mode(calibration_mode),
	.sense_phase_select(sense_phase_select));

// file: tb/host_master_model.sv
/*
 * Host processor model issuing decoded byte accesses to the register block.
 * Assumes accesses start just after a rising edge of clk_sys.
 */
`timescale 1ns/1ns
module host_master_model (
	input wire logic clk_sys,
	input wire logic [7:0] rd_data,
	input wire logic motor_running,
	output piezo_drive_pkg::host_access_s host_access
);
	logic [1:0] dead_sel_q;

	initial begin
		host_access = '0;
		dead_sel_q = 2'h0;
	end

	////////////////////////////////////////////////////////////////////////
	// one strobe cycle; address and data are scrambled once released
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		// never disturb the dead time while the bridges switch
		if (a == 8'h02 && motor_running) v[5:4] = dead_sel_q;
		if (a == 8'h02) dead_sel_q = v[5:4];
		@(posedge clk_sys);
		#1;
		host_access = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wr_data: v};
		@(posedge clk_sys);
		#1;
		host_access = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wr_data: ~v};
	endtask : write_reg

	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		#1;
		host_access = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wr_data: 8'h00};
		@(posedge clk_sys);
		#1;
		host_access = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wr_data: 8'hFF};
		d = rd_data;
	endtask : read_reg
endmodule : host_master_model

// file: tb/testbench.sv
/*
 * Self-checking bench of the piezo drive register block.
 * Assumes the host model and the bound checker are compiled alongside.
 */
`timescale 1ns/1ns
module testbench;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic power_down_pin_n = 1'b1;
	logic supply_above_threshold = 1'b0;
	piezo_drive_pkg::host_access_s host_access;
	piezo_drive_pkg::bridge_drive_s bridge_drive;
	logic [7:0] rd_data;
	logic period_tick, motor_running, full_bridge, calibration_run;
	logic [10:0] pulses_remaining;
	int err_total = 0;
	int total_checks = 0;
	int cyc = 0;

	always #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys) cyc <= cyc + 1;

	host_master_model hm (.clk_sys(clk_sys), .rd_data(rd_data), .motor_running(motor_running),
		.host_access(host_access));
	piezo_drive_register_control dut (.clk_sys(clk_sys), .reset_n(reset_n), .host_access(host_access),
		.power_down_pin_n(power_down_pin_n), .supply_above_threshold(supply_above_threshold),
		.rd_data(rd_data), .bridge_drive(bridge_drive), .period_tick(period_tick),
		.motor_running(motor_running), .direction(), .full_bridge(full_bridge),
		.calibration_run(calibration_run), .calibration_mode(), .sense_phase_select(),
		.pulses_remaining(pulses_remaining));

	////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : complete_run

	task automatic expect_reg(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		hm.read_reg(a, d);
		check("register", {a, d}, {a, e});
	endtask : expect_reg

	task automatic wait_cycles(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : wait_cycles

	// bounded wait so a dead period counter cannot hang the run
	task automatic next_tick(output int t);
		int k;
		k = 0;
		do begin
			@(posedge clk_sys);
			#1;
			k++;
		end while (period_tick !== 1'b1 && k < 1200);
		t = cyc;
	endtask : next_tick

	// three pulses at period n, plus offset when cal is zero; measure spacing, then expect a stop
	task automatic run_period(input logic [8:0] n, input logic [2:0] offs, input logic [1:0] cal, input int e);
		int t0, t1, t2;
		hm.write_reg(8'h01, n[7:0]);
		hm.write_reg(8'h06, {5'h00, offs});
		hm.write_reg(8'h00, {3'h3, 1'b0, cal, 2'h3});
		hm.write_reg(8'h02, {n[8], 7'h00});
		hm.write_reg(8'h03, 8'h03);
		check("running", 16'(motor_running), 16'h0001);
		next_tick(t0);
		next_tick(t1);
		next_tick(t2);
		check("period", 16'(t1 - t0), 16'(e));
		check("period", 16'(t2 - t1), 16'(e));
		wait_cycles(e);
		check("stopped", 16'({motor_running, pulses_remaining}), 16'h0000);
	endtask : run_period

	// one period of 125 with phase b off; both leg changes of phase a leave a gap of dead time
	task automatic dead_gap(input logic [7:0] sel, input logic [7:0] modes, input int e);
		int t, gap, b_on;
		gap = 0;
		b_on = 0;
		hm.write_reg(8'h00, 8'h62);
		hm.write_reg(8'h06, modes);
		hm.write_reg(8'h02, sel);
		hm.write_reg(8'h03, 8'h02);
		next_tick(t);
		repeat (125) begin
			@(posedge clk_sys);
			#1;
			if (!bridge_drive.a_high && !bridge_drive.a_low) gap++;
			if (bridge_drive.b_high || bridge_drive.b_low) b_on++;
		end
		check("dead gap", 16'(gap), 16'(e));
		check("phase b off", 16'(b_on), 16'h0000);
	endtask : dead_gap

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		logic [7:0] rst_tbl [8];
		int t;
		rst_tbl = '{8'h63, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80};
		wait_cycles(6);
		reset_n <= 1'b1;
		for (int i = 0; i < 8; i++) expect_reg(8'(i), rst_tbl[i]);
		// calibration held off until both count bytes are loaded
		hm.write_reg(8'h00, 8'h67);
		check("cal run", 16'(calibration_run), 16'h0000);
		hm.write_reg(8'h02, 8'h00);
		wait_cycles(2);
		check("cal run", 16'(calibration_run), 16'h0000);
		hm.write_reg(8'h03, 8'h00);
		wait_cycles(2);
		check("cal run", 16'(calibration_run), 16'h0001);
		for (int i = 0; i < 8; i++) hm.write_reg(8'(i), 8'hA8 + 8'(i));
		for (int i = 0; i < 8; i++) expect_reg(8'(i), i == 0 ? 8'h28 : 8'hA8 + 8'(i));
		hm.write_reg(8'h10, 8'hFF);
		expect_reg(8'h10, 8'h00);
		expect_reg(8'h08, 8'h00);
		run_period(9'h07D, 3'h0, 2'h0, 125);
		run_period(9'h07E, 3'h0, 2'h0, 126);
		run_period(9'h10A, 3'h0, 2'h0, 266);
		run_period(9'h07D, 3'h5, 2'h0, 130);
		run_period(9'h07D, 3'h5, 2'h1, 125);
		run_period(9'h07D, 3'h5, 2'h2, 125);
		// dead time stays at two cycles unless the long dead time mode is on
		dead_gap(8'h30, 8'h00, 4);
		dead_gap(8'h30, 8'h10, 16);
		dead_gap(8'h10, 8'h10, 8);
		// largest count, then hold, half bridge, blend and a zero write
		supply_above_threshold <= 1'b1;
		hm.write_reg(8'h06, 8'h00);
		hm.write_reg(8'h02, 8'h07);
		hm.write_reg(8'h03, 8'hFF);
		check("pulses", 16'(pulses_remaining), 16'h07FF);
		hm.write_reg(8'h06, 8'h80);
		wait_cycles(3);
		check("hold", 16'(motor_running), 16'h0000);
		hm.write_reg(8'h06, 8'h40);
		next_tick(t);
		next_tick(t);
		check("half bridge", 16'(full_bridge), 16'h0000);
		hm.write_reg(8'h07, 8'h00);
		hm.write_reg(8'h06, 8'h20);
		next_tick(t);
		next_tick(t);
		check("blend zero", 16'(full_bridge), 16'h0000);
		hm.write_reg(8'h07, 8'h80);
		next_tick(t);
		next_tick(t);
		check("blend full", 16'(full_bridge), 16'h0001);
		hm.write_reg(8'h02, 8'h00);
		hm.write_reg(8'h03, 8'h00);
		wait_cycles(3);
		check("zero stop", 16'({motor_running, bridge_drive}), 16'h0000);
		// power-down restores defaults and drops writes made while it lasts
		hm.write_reg(8'h07, 8'h11);
		power_down_pin_n <= 1'b0;
		wait_cycles(4);
		hm.write_reg(8'h01, 8'h55);
		power_down_pin_n <= 1'b1;
		wait_cycles(3);
		expect_reg(8'h07, 8'h80);
		expect_reg(8'h06, 8'h00);
		expect_reg(8'h01, 8'h00);
		complete_run();
	end

	// watchdog sized well past the expected few thousand cycles
	initial begin
		repeat (40000) @(posedge clk_sys);
		err_total++;
		complete_run();
	end
endmodule : testbench
